// ### sclk_pkg.sv
package sclk_pkg;

    typedef enum logic [2:0]
    {
        SRC_RC2M,
        SRC_RC32M,
        SRC_RC32K,
        SRC_XOSC,
        SRC_PLL,
        SRC_XTAL32K
    } sclk_src_t;

    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_PSCTRL    = 4'h1;
    localparam logic [3:0] ADDR_OSCEN     = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;
    localparam logic [3:0] ADDR_PLLCTRL   = 4'h4;
    localparam logic [3:0] ADDR_CAL32K    = 4'h5;
    localparam logic [3:0] ADDR_FLLCTRL   = 4'h6;
    localparam logic [3:0] ADDR_RTCCTRL   = 4'h7;
    localparam logic [3:0] ADDR_MONCTRL   = 4'h8;
    localparam logic [3:0] ADDR_INTFLAG   = 4'h9;
    localparam logic [3:0] ADDR_INTCLR    = 4'hA;
    localparam logic [3:0] ADDR_INTEN     = 4'hB;
    localparam logic [3:0] ADDR_CAL2M     = 4'hC;
    localparam logic [3:0] ADDR_CAL32M    = 4'hD;

    localparam int         NUM_SRC        = 6;
    localparam logic [5:0] OSCEN_RESET    = 6'h00;
    localparam logic [3:0] PS_RESET       = 4'h0;
    localparam logic [4:0] PLL_MUL_RESET  = 5'h01;
    localparam logic [7:0] CAL32K_DEFAULT = 8'h80;
    localparam logic [7:0] CAL_FAST_DEFAULT = 8'h80;
    localparam int         LP_DIV         = 32;
    localparam int         FLL_WINDOW     = 32;

    localparam int         INT_FAIL       = 0;
    localparam int         INT_SWITCH     = 1;
    localparam int         INT_REFUSED    = 2;
    localparam int         NUM_INT        = 3;

    typedef struct packed
    {
        logic       cpu_en;
        logic       periph_x2_en;
        logic       periph_x4_en;
    } sclk_enables_t;

    typedef struct packed
    {
        logic       low_power_osc_1k;
        logic       rc32k_full;
        logic       rc32k_div;
    } sclk_slow_t;

endpackage : sclk_pkg

// ### sclk_system_clock_control.sv
`timescale 1ns/1ps
// Summary of operation
// - Reset disables every source but the low-power oscillator and keeps calibrators and PLL off.
// - After reset the system clock selection is always the 2MHz internal oscillator.
// - Software may change source selection and prescalers at any time without reset.
// - Requested source switches happen only on a clock-enable boundary, but a failure fallback switches on any cycle.
// - With monitoring on, a failure of the external oscillator or PLL that drives the system clock forces the 2MHz oscillator and raises the NMI.
// - The PLL multiplier is an integer 1 to 31 and loss of lock counts as a failure.
// - The prescaler chain divides the system clock by one up to 2048.
// - Fast peripheral clocks run at two and four times the CPU clock beside the normal one.
// - The low-power oscillator gives a divided 1kHz tick and runs only while something uses it.
// - The calibrated 32.768kHz oscillator gives its full rate and a divided 1.024kHz output.
// - Its calibration loads a production default and software writes replace it.
// - An enabled frequency-locked calibrator keeps trimming the 2MHz or 32MHz oscillator against a reference.
// - The 32.768kHz crystal may serve as system clock, real-time counter clock and calibrator reference.
module sclk_system_clock_control
    import sclk_pkg::*;
#(
    parameter int PS_MAX_LOG = 11
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [7:0]       rdata,
    input  wire logic [5:0]  src_ready,
    input  wire logic        pll_locked,
    input  wire logic        xosc_fail,
    input  wire logic        low_power_osc_tick,
    input  wire logic        rc32k_tick,
    input  wire logic        ref_tick,
    input  wire logic        fast_osc_tick,
    input  wire logic        low_power_osc_demand,
    output logic [5:0]       src_enable,
    output logic             low_power_osc_en,
    output sclk_src_t        sys_clock_select,
    output logic [4:0]       pll_mul,
    output logic [7:0]       cal32k,
    output logic [7:0]       cal2m,
    output logic [7:0]       cal32m,
    output logic [1:0]       rtc_clock_select,
    output sclk_enables_t    clk_en,
    output sclk_slow_t       slow_ticks,
    output logic             nmi,
    output logic             irq
);

    logic [2:0]              req_src;
    logic [3:0]              ps_log;
    logic [3:0]              ps_active;
    logic [1:0]              fll_en;
    logic                    fll_ref_xtal;
    logic                    mon_en;
    logic [NUM_INT-1:0]      int_flag;
    logic [NUM_INT-1:0]      int_en;
    logic [NUM_INT-1:0]      int_set;
    logic [PS_MAX_LOG+1:0]   ps_cnt;
    logic                    base_tick;
    logic                    fail_now;
    logic                    fail_seen;
    logic                    switch_ok;
    logic                    sel_ext;
    logic [4:0]              lp_cnt;
    logic [4:0]              rc_cnt;
    logic [5:0]              fll_cnt;
    logic                    fll_ref;

    // An external source or PLL that drops out is a failure only while the external source or the PLL drives the system clock.
    assign sel_ext   = (sys_clock_select == SRC_XOSC) || (sys_clock_select == SRC_PLL);
    assign fail_now  = mon_en && sel_ext && (xosc_fail || ((sys_clock_select == SRC_PLL) && !pll_locked));
    // Codes above the last source select nothing, so they are refused rather than indexing past the enables.
    assign switch_ok = (req_src < 3'(NUM_SRC)) && src_enable[req_src] && src_ready[req_src];

    // The divider base tick comes every 2048 cycles, or every cycle at prescaler zero; requested switches happen only here, on the x4 pulse grid.
    assign base_tick = (ps_cnt[PS_MAX_LOG-1:0] == '0) || (ps_log == '0);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            src_enable <= OSCEN_RESET;
            pll_mul    <= PLL_MUL_RESET;
            ps_log     <= PS_RESET;
            fll_en     <= 2'b00;
            fll_ref_xtal <= 1'b0;
            mon_en     <= 1'b0;
            rtc_clock_select <= 2'b00;
            int_en     <= '0;
            cal32k     <= CAL32K_DEFAULT;
            req_src    <= SRC_RC2M;
        end
        else if (fail_now)
        begin
            // Dropping the failed request stops a flip back to it; a write in that one cycle is lost.
            req_src <= SRC_RC2M;
        end
        else if (wr)
        begin
            if (addr == ADDR_CTRL)
            begin
                req_src <= wdata[2:0];
            end
            else if (addr == ADDR_PSCTRL)
            begin
                ps_log <= (wdata[3:0] > 4'(PS_MAX_LOG)) ? 4'(PS_MAX_LOG) : wdata[3:0];
            end
            else if (addr == ADDR_OSCEN)
            begin
                src_enable <= wdata[5:0];
                src_enable[SRC_RC2M] <= wdata[SRC_RC2M] || (sys_clock_select == SRC_RC2M);
            end
            else if (addr == ADDR_PLLCTRL)
            begin
                pll_mul <= (wdata[4:0] == 5'h00) ? PLL_MUL_RESET : wdata[4:0];
            end
            else if (addr == ADDR_CAL32K)
            begin
                cal32k <= wdata;
            end
            else if (addr == ADDR_FLLCTRL)
            begin
                fll_en       <= wdata[1:0];
                fll_ref_xtal <= wdata[2];
            end
            else if (addr == ADDR_RTCCTRL)
            begin
                rtc_clock_select <= wdata[1:0];
            end
            else if (addr == ADDR_MONCTRL)
            begin
                mon_en <= wdata[0];
            end
            else if (addr == ADDR_INTEN)
            begin
                int_en <= wdata[NUM_INT-1:0];
            end
        end
    end

    // Selection follows the request only at a period boundary; failure overrides.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sys_clock_select <= SRC_RC2M;
            ps_active        <= PS_RESET;
            fail_seen        <= 1'b0;
        end
        else
        begin
            fail_seen <= fail_now;
            if (fail_now)
            begin
                sys_clock_select <= SRC_RC2M;
            end
            else if (base_tick)
            begin
                ps_active <= ps_log;
                if ((sclk_src_t'(req_src) != sys_clock_select) && switch_ok)
                begin
                    sys_clock_select <= sclk_src_t'(req_src);
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ps_cnt <= '0;
        end
        else
        begin
            ps_cnt <= ps_cnt + 1'b1;
        end
    end

    // Enable pulses: x4 at the base rate, x2 every second, CPU every fourth x4 pulse.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            clk_en <= '0;
        end
        else
        begin
            clk_en.periph_x4_en <= (ps_cnt[PS_MAX_LOG-1:0] & ((12'(1) << ps_active) - 12'(1))) == '0;
            clk_en.periph_x2_en <= (ps_cnt[PS_MAX_LOG:0] & ((13'(2) << ps_active) - 13'(1))) == '0;
            clk_en.cpu_en       <= (ps_cnt & ((14'(4) << ps_active) - 14'(1))) == '0;
        end
    end

    assign int_set[INT_FAIL]    = fail_now && !fail_seen;
    assign int_set[INT_SWITCH]  = base_tick && !fail_now && (sclk_src_t'(req_src) != sys_clock_select) && switch_ok;
    assign int_set[INT_REFUSED] = wr && (addr == ADDR_CTRL)
        && !((wdata[2:0] < 3'(NUM_SRC)) && src_enable[wdata[2:0]] && src_ready[wdata[2:0]]);

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            int_flag <= '0;
        end
        else
        begin
            int_flag <= (int_flag & ~((wr && addr == ADDR_INTCLR) ? wdata[NUM_INT-1:0] : '0)) | int_set;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            nmi <= 1'b0;
        end
        else
        begin
            nmi <= fail_now && !fail_seen;
        end
    end

    assign irq = |(int_flag & int_en);

    // The low-power oscillator runs while the RTC or any other consumer asks for it.
    assign low_power_osc_en = (rtc_clock_select == 2'b00) || low_power_osc_demand;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            lp_cnt     <= '0;
            rc_cnt     <= '0;
            slow_ticks <= '0;
        end
        else
        begin
            slow_ticks.low_power_osc_1k <= 1'b0;
            slow_ticks.rc32k_full       <= rc32k_tick && src_enable[SRC_RC32K];
            slow_ticks.rc32k_div        <= 1'b0;
            if (low_power_osc_tick && low_power_osc_en)
            begin
                lp_cnt <= lp_cnt + 1'b1;
                slow_ticks.low_power_osc_1k <= (lp_cnt == 5'(LP_DIV - 1));
            end
            if (rc32k_tick && src_enable[SRC_RC32K])
            begin
                rc_cnt <= rc_cnt + 1'b1;
                slow_ticks.rc32k_div <= (rc_cnt == 5'(LP_DIV - 1));
            end
        end
    end

    // Each reference tick compares the fast-oscillator count with the target and nudges the trim by one when they differ.
    assign fll_ref = fll_ref_xtal ? (ref_tick && src_enable[SRC_XTAL32K]) : slow_ticks.rc32k_div;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fll_cnt <= '0;
            cal2m   <= CAL_FAST_DEFAULT;
            cal32m  <= CAL_FAST_DEFAULT;
        end
        else if (fll_ref)
        begin
            fll_cnt <= '0;
            if (fll_en[0] && fll_cnt != 6'(FLL_WINDOW))
            begin
                cal2m <= (fll_cnt < 6'(FLL_WINDOW)) ? cal2m + 1'b1 : cal2m - 1'b1;
            end
            if (fll_en[1] && fll_cnt != 6'(FLL_WINDOW))
            begin
                cal32m <= (fll_cnt < 6'(FLL_WINDOW)) ? cal32m + 1'b1 : cal32m - 1'b1;
            end
        end
        else if (fast_osc_tick && fll_cnt != 6'h3F)
        begin
            fll_cnt <= fll_cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= '0;
        end
        else if (rd)
        begin
            if (addr == ADDR_CTRL)
                rdata <= {5'h00, sys_clock_select};
            else if (addr == ADDR_PSCTRL)
                rdata <= {4'h0, ps_log};
            else if (addr == ADDR_OSCEN)
                rdata <= {2'b00, src_enable};
            else if (addr == ADDR_STATUS)
                rdata <= {1'b0, pll_locked, src_enable & src_ready};
            else if (addr == ADDR_PLLCTRL)
                rdata <= {3'h0, pll_mul};
            else if (addr == ADDR_CAL32K)
                rdata <= cal32k;
            else if (addr == ADDR_FLLCTRL)
                rdata <= {5'h00, fll_ref_xtal, fll_en};
            else if (addr == ADDR_RTCCTRL)
                rdata <= {6'h00, rtc_clock_select};
            else if (addr == ADDR_MONCTRL)
                rdata <= {7'h00, mon_en};
            else if (addr == ADDR_INTFLAG)
                rdata <= {5'h00, int_flag};
            else if (addr == ADDR_INTEN)
                rdata <= {5'h00, int_en};
            else if (addr == ADDR_CAL2M)
                rdata <= cal2m;
            else if (addr == ADDR_CAL32M)
                rdata <= cal32m;
            else
                rdata <= 8'h00;
        end
    end

endmodule : sclk_system_clock_control

// ### sclk_system_clock_control_chk.sv
`timescale 1ns/1ps
module sclk_system_clock_control_chk
    import sclk_pkg::*;
(
    input wire logic          mclk,
    input wire logic          rst,
    input wire logic [3:0]    addr,
    input wire logic [7:0]    wdata,
    input wire logic          wr,
    input wire logic          rd,
    input wire logic [7:0]    rdata,
    input wire logic [5:0]    src_ready,
    input wire logic          pll_locked,
    input wire logic          low_power_osc_demand,
    input wire logic [5:0]    src_enable,
    input wire logic          low_power_osc_en,
    input wire sclk_src_t     sys_clock_select,
    input wire logic [4:0]    pll_mul,
    input wire logic [1:0]    rtc_clock_select,
    input wire sclk_enables_t clk_en,
    input wire logic          nmi
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Only checked from the 2MHz source, where no failure fallback can move the selection.
    chk_refuse_keeps_sel: assert property (wr && addr == ADDR_CTRL && sys_clock_select == SRC_RC2M
        && wdata[2:0] != 3'h0 && ((src_enable & src_ready) & (6'h01 << wdata[2:0])) == 6'h00
        |=> sys_clock_select == SRC_RC2M) else $error("Refused switch changed the source");
    chk_sel_needs_ready: assert property ($changed(sys_clock_select) && sys_clock_select != SRC_RC2M
        |-> ($past(src_enable & src_ready) & (6'h01 << sys_clock_select)) != 6'h00)
        else $error("Switched to a source not enabled and ready");
    chk_nmi_to_rc2m: assert property (nmi |-> sys_clock_select == SRC_RC2M)
        else $error("Failure pulse without fallback source");
    chk_nmi_single: assert property (nmi |=> !nmi)
        else $error("Failure pulse longer than one cycle");
    chk_x2_on_x4: assert property (clk_en.periph_x2_en |-> clk_en.periph_x4_en)
        else $error("Double rate enable off the quad rate grid");
    chk_cpu_on_x2: assert property (clk_en.cpu_en |-> clk_en.periph_x2_en)
        else $error("CPU enable off the double rate grid");
    chk_unmapped_zero: assert property (rd && addr > ADDR_CAL32M |=> rdata == 8'h00)
        else $error("Unmapped read not zero");
    chk_status_read: assert property (rd && addr == ADDR_STATUS
        |=> rdata == {1'h0, $past(pll_locked), $past(src_enable & src_ready)}) else $error("Status read wrong");
    chk_pll_write: assert property (wr && addr == ADDR_PLLCTRL
        |=> pll_mul == (($past(wdata[4:0]) == 5'h00) ? 5'h01 : $past(wdata[4:0]))) else $error("Multiplier wrong");
    chk_lp_demand: assert property (low_power_osc_en == (rtc_clock_select == 2'h0 || low_power_osc_demand))
        else $error("Low power oscillator enable wrong");

    cover property (nmi);
    cover property ($changed(sys_clock_select) && sys_clock_select == SRC_PLL);
    cover property (clk_en.cpu_en);
endmodule : sclk_system_clock_control_chk

// ### sclk_system_clock_control_tb.sv
`timescale 1ns/1ps
module sclk_system_clock_control_tb
    import sclk_pkg::*;
;
    logic          mclk, rst, wr, rd, pll_locked, xosc_fail, low_power_osc_demand, low_power_osc_en, nmi, irq;
    logic [3:0]    addr;
    logic [7:0]    wdata, rdata, cal32k;
    logic [5:0]    src_ready, src_enable;
    logic [4:0]    pll_mul;
    logic [1:0]    rtc_clock_select;
    sclk_src_t     sys_clock_select;
    sclk_enables_t clk_en;
    int            mismatches = 0;
    int            checked = 0;
    int            ps_tab [3] = '{0, 2, 11};

    sclk_system_clock_control DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .src_ready(src_ready), .pll_locked(pll_locked), .xosc_fail(xosc_fail),
        .low_power_osc_tick(1'h0), .rc32k_tick(1'h0), .ref_tick(1'h0), .fast_osc_tick(1'h0),
        .low_power_osc_demand(low_power_osc_demand), .src_enable(src_enable), .low_power_osc_en(low_power_osc_en),
        .sys_clock_select(sys_clock_select), .pll_mul(pll_mul), .cal32k(cal32k), .cal2m(), .cal32m(),
        .rtc_clock_select(rtc_clock_select), .clk_en(clk_en), .slow_ticks(), .nmi(nmi), .irq(irq));

    initial
    begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
        #1;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        check(rdata, exp);
    endtask : reg_rd

    // Every wait is bounded; a wait_sig timeout ends the run as a failure, the others only count a mismatch.
    task automatic wait_sig(input int b, input int lim);
        int n;
        n = 0;
        while ((b < 0 ? nmi : clk_en[b]) !== 1'h1 && n < lim)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if ((b < 0 ? nmi : clk_en[b]) !== 1'h1)
        begin
            check(n, 0);
            print_verdict();
        end
    endtask : wait_sig

    task automatic wait_fail;
        wait_sig(-1, 8);
        check(sys_clock_select, SRC_RC2M);
    endtask : wait_fail

    task automatic wait_sel(input sclk_src_t s);
        repeat (32) if (sys_clock_select !== s) @(posedge mclk);
        #1;
        check(sys_clock_select, s);
    endtask : wait_sel

    task automatic gap(input int b, input int exp);
        int n;
        wait_sig(b, 20000);
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end while (clk_en[b] !== 1'h1 && n < 20000);
        check(n, exp);
    endtask : gap

    initial
    begin
        rst = 1'h1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'h0;
        rd = 1'h0;
        src_ready = 6'h00;
        pll_locked = 1'h0;
        xosc_fail = 1'h0;
        low_power_osc_demand = 1'h0;
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        #1;
        check(src_enable, OSCEN_RESET);
        check(sys_clock_select, SRC_RC2M);
        check(pll_mul, PLL_MUL_RESET);
        check(cal32k, CAL32K_DEFAULT);
        check(low_power_osc_en, 1'h1);
        reg_wr(ADDR_CAL32K, 8'h5A);
        reg_rd(ADDR_CAL32K, 8'h5A);
        reg_rd(4'hF, 8'h00);
        reg_wr(ADDR_PLLCTRL, 8'h00);
        check(pll_mul, 5'h01);
        reg_wr(ADDR_PLLCTRL, 8'h1F);
        check(pll_mul, 5'h1F);
        reg_wr(ADDR_INTEN, 8'h07);
        reg_wr(ADDR_CTRL, 8'h03);
        reg_rd(ADDR_INTFLAG, 8'h04);
        check(sys_clock_select, SRC_RC2M);
        check(irq, 1'h1);
        reg_wr(ADDR_INTCLR, 8'h04);
        check(irq, 1'h0);
        src_ready <= 6'h08;
        reg_wr(ADDR_OSCEN, 8'h08);
        reg_wr(ADDR_CTRL, 8'h03);
        wait_sel(SRC_XOSC);
        reg_rd(ADDR_STATUS, 8'h08);
        reg_wr(ADDR_MONCTRL, 8'h01);
        xosc_fail <= 1'h1;
        wait_fail();
        reg_rd(ADDR_INTFLAG, 8'h03);
        xosc_fail <= 1'h0;
        src_ready <= 6'h18;
        pll_locked <= 1'h1;
        reg_wr(ADDR_OSCEN, 8'h18);
        reg_rd(ADDR_STATUS, 8'h58);
        reg_wr(ADDR_CTRL, 8'h04);
        wait_sel(SRC_PLL);
        pll_locked <= 1'h0;
        wait_fail();
        reg_wr(ADDR_CTRL, 8'h03);
        wait_sel(SRC_XOSC);
        rst <= 1'h1;
        @(posedge mclk);
        rst <= 1'h0;
        #1;
        check(sys_clock_select, SRC_RC2M);
        check(src_enable, OSCEN_RESET);
        foreach (ps_tab[i])
        begin
            reg_wr(ADDR_PSCTRL, 8'(ps_tab[i]));
            repeat (2050) @(posedge mclk);
            #1;
            for (int b = 0; b < 3; b++)
                gap(b, 1 << (ps_tab[i] + b));
        end
        reg_wr(ADDR_RTCCTRL, 8'h01);
        check(low_power_osc_en, 1'h0);
        low_power_osc_demand <= 1'h1;
        @(posedge mclk);
        #1;
        check(low_power_osc_en, 1'h1);
        print_verdict();
    end
endmodule : sclk_system_clock_control_tb

bind sclk_system_clock_control sclk_system_clock_control_chk u_chk (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src_ready(src_ready), .pll_locked(pll_locked),
    .low_power_osc_demand(low_power_osc_demand), .src_enable(src_enable), .low_power_osc_en(low_power_osc_en),
    .sys_clock_select(sys_clock_select), .pll_mul(pll_mul), .rtc_clock_select(rtc_clock_select),
    .clk_en(clk_en), .nmi(nmi));
